// File: logic/fclr_pkg.sv
// Constants, register map and state layout of the fan control limit bank
package fclr_pkg;

	localparam int NCH    = 3;
	localparam int BANK_N = 13;

	// Printed offsets are register indices; byte address is four times the index
	localparam logic [6:0] IDX_PWM1_MIN_DUTY       = 7'h64;
	localparam logic [6:0] IDX_PWM2_MIN_DUTY       = 7'h65;
	localparam logic [6:0] IDX_PWM3_MIN_DUTY       = 7'h66;
	localparam logic [6:0] IDX_REMOTE1_START_TEMP  = 7'h67;
	localparam logic [6:0] IDX_LOCAL_START_TEMP    = 7'h68;
	localparam logic [6:0] IDX_REMOTE2_START_TEMP  = 7'h69;
	localparam logic [6:0] IDX_REMOTE1_CRIT_LIMIT  = 7'h6A;
	localparam logic [6:0] IDX_LOCAL_CRIT_LIMIT    = 7'h6B;
	localparam logic [6:0] IDX_REMOTE2_CRIT_LIMIT  = 7'h6C;
	localparam logic [6:0] IDX_R1_LOCAL_HYSTERESIS = 7'h6D;
	localparam logic [6:0] IDX_REMOTE2_HYSTERESIS  = 7'h6E;
	localparam logic [6:0] IDX_PIN_TREE_TEST_EN    = 7'h6F;
	localparam logic [6:0] IDX_REMOTE1_TEMP_OFFSET = 7'h70;
	localparam logic [6:0] IDX_CTRL                = 7'h40;
	localparam logic [6:0] IDX_IRQ_STATUS          = 7'h41;
	localparam logic [6:0] IDX_IRQ_MASK            = 7'h42;

	// Slots of the bank storage, counted from the first index
	localparam int SLOT_MIN_DUTY = 0;
	localparam int SLOT_START    = 3;
	localparam int SLOT_CRIT     = 6;
	localparam int SLOT_HYST_A   = 9;
	localparam int SLOT_HYST_B   = 10;
	localparam int SLOT_TEST     = 11;
	localparam int SLOT_OFFSET   = 12;

	// Power-on values, slot 12 down to slot 0
	localparam logic [BANK_N-1:0][7:0] BANK_RESET = {
		8'h00, 8'h00, 8'h40, 8'h44,
		8'h64, 8'h64, 8'h64,
		8'h5A, 8'h5A, 8'h5A,
		8'h80, 8'h80, 8'h80
	};

	localparam logic [7:0] DUTY_FULL     = 8'hFF;
	localparam logic [7:0] DUTY_OFF      = 8'h00;
	localparam logic [7:0] CRIT_DISABLE  = 8'h80;
	localparam logic [7:0] TEST_EN_MASK  = 8'h01;
	localparam int         TEST_EN_BIT   = 0;
	localparam int         HYST_W        = 4;
	localparam int         HYST_LO_LSB   = 0;
	localparam int         HYST_HI_LSB   = 4;
	localparam int         TEMP_W        = 10;
	localparam int         CALC_W        = 12;

	// Control register bits
	localparam int CTRL_AUTO      = 0;
	localparam int CTRL_LOCK      = 1;
	localparam int CTRL_OFS_RANGE = 2;
	localparam int CTRL_ALARM_OUT = 3;
	localparam int CTRL_W         = 4;

	// Interrupt status and mask bits
	localparam int IRQ_FS0   = 0;
	localparam int IRQ_ALARM = 3;
	localparam int IRQ_EXT   = 4;
	localparam int IRQ_W     = 5;

	typedef struct packed {
		logic [BANK_N-1:0][7:0] bank;
		logic [CTRL_W-1:0]      ctrl;
		logic [IRQ_W-1:0]       status;
		logic [IRQ_W-1:0]       mask;
		logic [NCH-1:0]         fan_on;
		logic [NCH-1:0]         fail_safe;
		logic [NCH-1:0][7:0]    duty;
		logic                   alarm_oe;
		logic [2:0]             pin_sync;
		logic [31:0]            rdata;
	} fclr_state_s;

endpackage

// File: logic/fclr_top.sv
// Fan control limit register bank with fail-safe and fan loop thresholds
//
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
// How it works
// R01: Each minimum-duty byte maps linearly onto its fan's lowest PWM duty, 0x00 off to 0xFF full.
// R02: While the automatic fan loop is on, writes to the minimum-duty bytes are dropped.
// R03: All three minimum-duty bytes come out of reset at 0x80, half duty.
// R04: Above its start temperature a channel's fan runs at minimum duty and ramps up with temperature.
// R05: With the lock bit set, start, limit, hysteresis, test and offset bytes ignore writes.
// R06: Any channel above its critical limit forces every PWM output to full duty.
// R07: A critical limit of 0x80 disables the fail-safe for that channel.
// R08: Fail-safe full duty holds until the temperature drops below limit minus hysteresis.
// R09: With the alarm pin set as output, a quarter degree over a limit drives it low.
// R10: The first hysteresis byte carries local in bits 3:0 and remote 1 in bits 7:4.
// R11: Below start temperature the fan stays at minimum duty until start minus hysteresis.
// R12: Software should keep hysteresis at four degrees or more to avoid fan cycling.
// R13: Bit 0 of the test enable byte switches the pin tree test mode on and off.
// R14: Software leaves bits 7:1 of the test enable byte alone; they read as zero.
// R15: The remote 1 offset is added to every remote 1 reading, step chosen by a range bit.
// R16: Every byte of the bank is read and written one byte at a time at its own address.
module fclr_top
	import fclr_pkg::*;
#(
	parameter int DUTY_STEP = 8
) (
	input  wire logic              core_clk,
	input  wire logic              resetn,
	input  wire logic              ce,
	input  wire logic [11:0]       paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [TEMP_W-1:0] remote1_temp,
	input  wire logic [TEMP_W-1:0] local_temp,
	input  wire logic [TEMP_W-1:0] remote2_temp,
	output logic      [7:0]        pwm1_duty,
	output logic      [7:0]        pwm2_duty,
	output logic      [7:0]        pwm3_duty,
	input  wire logic              thermal_alarm_pin_i,
	output logic                   thermal_alarm_pin_o,
	output logic                   thermal_alarm_pin_oe,
	output logic                   pin_tree_test_on,
	output logic                   irq
);

	// R03: min duty at half
	localparam fclr_state_s STATE_RESET = '{bank: BANK_RESET, default: '0};

	fclr_state_s s_q;
	fclr_state_s s_d;

	logic [NCH-1:0][TEMP_W-1:0] temp_raw;
	logic [NCH-1:0][CALC_W-1:0] ofs_add;
	logic [NCH-1:0][HYST_W-1:0] hyst;
	logic [NCH-1:0]             fan_set;
	logic [NCH-1:0]             fan_clr;
	logic [NCH-1:0]             fs_set;
	logic [NCH-1:0]             fs_clr;
	logic [NCH-1:0][7:0]        duty_auto;
	logic                       acc;
	logic                       setup;
	logic                       wr;
	logic                       addr_ok;
	logic [6:0]                 idx;
	logic                       in_bank;
	logic [6:0]                 slot_w;
	logic                       mapped;
	logic [31:0]                rd_val;

	assign temp_raw[0] = remote1_temp;
	assign temp_raw[1] = local_temp;
	assign temp_raw[2] = remote2_temp;

	// R10: hysteresis nibble placement
	assign hyst[0] = s_q.bank[SLOT_HYST_A][HYST_HI_LSB +: HYST_W];
	assign hyst[1] = s_q.bank[SLOT_HYST_A][HYST_LO_LSB +: HYST_W];
	assign hyst[2] = s_q.bank[SLOT_HYST_B][HYST_HI_LSB +: HYST_W];

	// R15: remote 1 offset, half or whole degree steps
	assign ofs_add[0] = s_q.ctrl[CTRL_OFS_RANGE] ?
		{{2{s_q.bank[SLOT_OFFSET][7]}}, s_q.bank[SLOT_OFFSET], 2'b00} :
		{{3{s_q.bank[SLOT_OFFSET][7]}}, s_q.bank[SLOT_OFFSET], 1'b0};
	assign ofs_add[1] = '0;
	assign ofs_add[2] = '0;

	// Per channel thresholds, all in signed quarter degrees
	genvar c;
	generate
		for (c = 0; c < NCH; c++) begin : g_ch
			logic signed [CALC_W-1:0] sum;
			logic signed [CALC_W-1:0] t;
			logic signed [CALC_W-1:0] start4;
			logic signed [CALC_W-1:0] crit4;
			logic signed [CALC_W-1:0] hy4;
			logic signed [CALC_W-1:0] excess;
			logic        [15:0]       ramp;
			logic        [7:0]        min_duty;
			logic        [7:0]        lim;

			assign min_duty = s_q.bank[SLOT_MIN_DUTY + c];
			assign lim      = s_q.bank[SLOT_CRIT + c];
			assign sum      = $signed({2'b00, temp_raw[c]}) + $signed(ofs_add[c]);
			// Corrected reading clipped to the input range
			assign t        = sum[CALC_W-1] ? '0 :
				(sum > $signed({2'b00, {TEMP_W{1'b1}}})) ? $signed({2'b00, {TEMP_W{1'b1}}}) : sum;
			assign start4   = $signed({2'b00, s_q.bank[SLOT_START + c], 2'b00});
			assign crit4    = $signed({2'b00, lim, 2'b00});
			assign hy4      = $signed({{(CALC_W-HYST_W-2){1'b0}}, hyst[c], 2'b00});
			// R11: start and stop points of the fan
			assign fan_set[c] = t > start4;
			assign fan_clr[c] = t < (start4 - hy4);
			// R07: limit value that disables the fail-safe
			assign fs_set[c]  = (lim != CRIT_DISABLE) && (t > crit4);
			// R08: release point below the limit
			assign fs_clr[c]  = (lim == CRIT_DISABLE) || (t < (crit4 - hy4));
			assign excess     = t - start4;
			// R04: ramp above start temperature
			assign ramp       = 16'(min_duty) +
				(excess[CALC_W-1] ? 16'h0000 : 16'(excess[CALC_W-1:2]) * 16'(DUTY_STEP));
			assign duty_auto[c] = (ramp > 16'(DUTY_FULL)) ? DUTY_FULL : ramp[7:0];
		end
	endgenerate

	// APB decode
	assign setup   = psel & ~penable;
	assign acc     = psel & penable;
	assign idx     = paddr[8:2];
	assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[11:9] == 3'b000);
	assign in_bank = (idx >= IDX_PWM1_MIN_DUTY) && (idx <= IDX_REMOTE1_TEMP_OFFSET);
	assign slot_w  = idx - IDX_PWM1_MIN_DUTY;
	assign mapped  = addr_ok && (in_bank || idx == IDX_CTRL || idx == IDX_IRQ_STATUS || idx == IDX_IRQ_MASK);
	// R16: byte wide access, only byte lane 0 writes
	assign wr      = acc & pwrite & pstrb[0] & mapped;

	always_comb begin
		rd_val = '0;
		if (mapped) begin
			if (in_bank) begin
				rd_val[7:0] = s_q.bank[slot_w];
			end else if (idx == IDX_CTRL) begin
				rd_val[CTRL_W-1:0] = s_q.ctrl;
			end else if (idx == IDX_IRQ_STATUS) begin
				rd_val[IRQ_W-1:0] = s_q.status;
			end else begin
				rd_val[IRQ_W-1:0] = s_q.mask;
			end
		end
	end

	always_comb begin
		logic [IRQ_W-1:0] ev;
		logic [IRQ_W-1:0] clr;
		ev  = '0;
		clr = '0;
		s_d = s_q;

		if (setup) begin
			s_d.rdata = rd_val;
		end

		if (wr && in_bank) begin
			if (slot_w < 7'(SLOT_START)) begin
				// R02: min duty frozen under automatic loop
				if (!s_q.ctrl[CTRL_AUTO]) begin
					s_d.bank[slot_w] = pwdata[7:0];
				end
			end else if (!s_q.ctrl[CTRL_LOCK]) begin
				// R05: lock blocks the limit bytes
				if (slot_w == 7'(SLOT_TEST)) begin
					// R14: reserved test bits kept at zero
					s_d.bank[slot_w] = pwdata[7:0] & TEST_EN_MASK;
				end else begin
					s_d.bank[slot_w] = pwdata[7:0];
				end
			end
		end
		if (wr && idx == IDX_CTRL) begin
			s_d.ctrl = pwdata[CTRL_W-1:0];
			s_d.ctrl[CTRL_LOCK] = s_q.ctrl[CTRL_LOCK] | pwdata[CTRL_LOCK];
		end
		if (wr && idx == IDX_IRQ_MASK) begin
			s_d.mask = pwdata[IRQ_W-1:0];
		end
		if (wr && idx == IDX_IRQ_STATUS) begin
			clr = pwdata[IRQ_W-1:0];
		end

		for (int i = 0; i < NCH; i++) begin
			// R11: fan on with hysteresis
			if (s_q.fan_on[i]) begin
				s_d.fan_on[i] = ~fan_clr[i];
			end else begin
				s_d.fan_on[i] = fan_set[i];
			end
			// R06: fail-safe entry and hold
			if (s_q.fail_safe[i]) begin
				s_d.fail_safe[i] = ~fs_clr[i];
			end else begin
				s_d.fail_safe[i] = fs_set[i];
			end
			ev[IRQ_FS0 + i] = s_d.fail_safe[i] & ~s_q.fail_safe[i];
		end

		for (int i = 0; i < NCH; i++) begin
			if (|s_d.fail_safe) begin
				// R06: all outputs to full duty
				s_d.duty[i] = DUTY_FULL;
			end else if (!s_q.ctrl[CTRL_AUTO]) begin
				// R01: duty taken straight from the byte
				s_d.duty[i] = s_q.bank[SLOT_MIN_DUTY + i];
			end else if (s_d.fan_on[i]) begin
				// R04: minimum duty plus ramp
				s_d.duty[i] = fan_set[i] ? duty_auto[i] : s_q.bank[SLOT_MIN_DUTY + i];
			end else begin
				s_d.duty[i] = DUTY_OFF;
			end
		end

		// R09: alarm pin driven low when over a limit
		s_d.alarm_oe = s_q.ctrl[CTRL_ALARM_OUT] & (|fs_set);
		ev[IRQ_ALARM] = s_d.alarm_oe & ~s_q.alarm_oe;

		// Pin synchroniser and falling edge while pin is an input
		s_d.pin_sync = {s_q.pin_sync[1:0], thermal_alarm_pin_i};
		ev[IRQ_EXT] = ~s_q.ctrl[CTRL_ALARM_OUT] & s_q.pin_sync[2] & ~s_q.pin_sync[1];

		// Set wins over a same cycle clear
		s_d.status = (s_q.status & ~clr) | ev;
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= STATE_RESET;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign prdata               = s_q.rdata;
	assign pready               = 1'b1;
	assign pslverr              = acc & ~mapped;
	assign pwm1_duty            = s_q.duty[0];
	assign pwm2_duty            = s_q.duty[1];
	assign pwm3_duty            = s_q.duty[2];
	assign thermal_alarm_pin_o  = 1'b0;
	assign thermal_alarm_pin_oe = s_q.alarm_oe;
	// R13: test mode follows bit 0
	assign pin_tree_test_on     = s_q.bank[SLOT_TEST][TEST_EN_BIT];
	assign irq                  = |(s_q.status & s_q.mask);

	property p_min_duty_locked_auto;
		@(posedge core_clk) disable iff (!resetn)
		ce && wr && in_bank && slot_w < 7'(SLOT_START) && s_q.ctrl[CTRL_AUTO]
		|=> s_q.bank[SLOT_START-1:SLOT_MIN_DUTY] == $past(s_q.bank[SLOT_START-1:SLOT_MIN_DUTY]);
	endproperty
	a_min_duty_locked_auto: assert property (p_min_duty_locked_auto) else $error("min duty changed under auto loop"); // R02

	property p_min_duty_reset;
		@(posedge core_clk) disable iff (!resetn)
		!$past(resetn) |-> s_q.bank[SLOT_MIN_DUTY] == 8'h80 && s_q.bank[SLOT_MIN_DUTY + 2] == 8'h80;
	endproperty
	a_min_duty_reset: assert property (p_min_duty_reset) else $error("min duty not half after reset"); // R03

	property p_lock_blocks;
		@(posedge core_clk) disable iff (!resetn)
		ce && wr && in_bank && slot_w >= 7'(SLOT_START) && s_q.ctrl[CTRL_LOCK]
		|=> s_q.bank[BANK_N-1:SLOT_START] == $past(s_q.bank[BANK_N-1:SLOT_START]);
	endproperty
	a_lock_blocks: assert property (p_lock_blocks) else $error("locked limit was written"); // R05

	property p_fail_safe_full;
		@(posedge core_clk) disable iff (!resetn)
		ce && (|fs_set) |=> pwm1_duty == DUTY_FULL && pwm2_duty == DUTY_FULL && pwm3_duty == DUTY_FULL;
	endproperty
	a_fail_safe_full: assert property (p_fail_safe_full) else $error("fail-safe did not force full duty"); // R06

	property p_crit_disable;
		@(posedge core_clk) disable iff (!resetn)
		ce && s_q.bank[SLOT_CRIT + 1] == CRIT_DISABLE |=> !s_q.fail_safe[1];
	endproperty
	a_crit_disable: assert property (p_crit_disable) else $error("disabled limit raised fail-safe"); // R07

	property p_fail_safe_hold;
		@(posedge core_clk) disable iff (!resetn)
		ce && s_q.fail_safe[1] && !fs_clr[1] |=> s_q.fail_safe[1] && pwm2_duty == DUTY_FULL;
	endproperty
	a_fail_safe_hold: assert property (p_fail_safe_hold) else $error("fail-safe released early"); // R08

	property p_alarm_pin;
		@(posedge core_clk) disable iff (!resetn)
		ce && s_q.ctrl[CTRL_ALARM_OUT] && (|fs_set) |=> thermal_alarm_pin_oe && !thermal_alarm_pin_o;
	endproperty
	a_alarm_pin: assert property (p_alarm_pin) else $error("alarm pin not driven low"); // R09

	property p_fan_hold;
		@(posedge core_clk) disable iff (!resetn)
		s_q.fan_on[2] && !fan_clr[2] |=> s_q.fan_on[2];
	endproperty
	a_fan_hold: assert property (p_fan_hold) else $error("fan stopped inside hysteresis"); // R11

	property p_test_mode;
		@(posedge core_clk) disable iff (!resetn)
		ce && wr && in_bank && slot_w == 7'(SLOT_TEST) && !s_q.ctrl[CTRL_LOCK]
		|=> pin_tree_test_on == $past(pwdata[TEST_EN_BIT]) && s_q.bank[SLOT_TEST][7:1] == 7'h00;
	endproperty
	a_test_mode: assert property (p_test_mode) else $error("test mode bit not taken"); // R13

	property p_manual_duty;
		@(posedge core_clk) disable iff (!resetn)
		ce && !s_q.ctrl[CTRL_AUTO] && !(|s_d.fail_safe) |=> pwm3_duty == $past(s_q.bank[SLOT_MIN_DUTY + 2]);
	endproperty
	a_manual_duty: assert property (p_manual_duty) else $error("manual duty not from min duty byte"); // R01

endmodule

// File: verif/fclr_alarm_wire.sv
// Open-drain alarm wire with pull-up and an outside puller
`timescale 1ns/100ps
module fclr_alarm_wire (
	input  wire logic link_clk,
	input  wire logic ext_pull,
	input  wire logic dut_o,
	input  wire logic dut_oe,
	output logic      pin
);
	logic pull_q = 1'b0;

	// Outside puller acts on its own clock
	always @(posedge link_clk) begin
		pull_q <= ext_pull;
	end

	assign pin = ((dut_oe && !dut_o) || pull_q) ? 1'b0 : 1'b1;
endmodule

// File: verif/testbench.sv
// Self-checking bench of the fan control limit bank
`timescale 1ns/100ps
module testbench
	import fclr_pkg::*;
;
	logic              core_clk = 1'b0;
	logic              link_clk = 1'b0;
	logic              resetn   = 1'b0;
	logic [11:0]       paddr    = 12'h000;
	logic              psel     = 1'b0;
	logic              penable  = 1'b0;
	logic              pwrite   = 1'b0;
	logic [31:0]       pwdata   = 32'h0;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic [TEMP_W-1:0] r1_t     = 10'd200;
	logic [TEMP_W-1:0] lc_t     = 10'd200;
	logic [TEMP_W-1:0] r2_t     = 10'd200;
	logic [7:0]        pwm1;
	logic [7:0]        pwm2;
	logic [7:0]        pwm3;
	logic              pin;
	logic              pin_o;
	logic              pin_oe;
	logic              test_on;
	logic              irq;
	logic              ext_pull = 1'b0;
	logic [31:0]       rv;
	logic              ev;
	int                err_total       = 0;
	int                samples_checked = 0;
	int                cycles          = 0;
	logic [7:0]        rst_tab [13]    = '{8'h80, 8'h80, 8'h80, 8'h5A, 8'h5A, 8'h5A, 8'h64, 8'h64, 8'h64,
		8'h44, 8'h40, 8'h00, 8'h00};

	always #5 core_clk = ~core_clk;
	always #40 link_clk = ~link_clk;

	fclr_top u_dut (.core_clk(core_clk), .resetn(resetn), .ce(1'b1), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .remote1_temp(r1_t), .local_temp(lc_t),
		.remote2_temp(r2_t), .pwm1_duty(pwm1), .pwm2_duty(pwm2), .pwm3_duty(pwm3),
		.thermal_alarm_pin_i(pin), .thermal_alarm_pin_o(pin_o), .thermal_alarm_pin_oe(pin_oe),
		.pin_tree_test_on(test_on), .irq(irq));

	fclr_alarm_wire u_wire (.link_clk(link_clk), .ext_pull(ext_pull), .dut_o(pin_o),
		.dut_oe(pin_oe), .pin(pin));

	task automatic stop_test();
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task automatic bus(input logic wr, input logic [6:0] idx, input logic [7:0] wd);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= {3'h0, idx, 2'h0};
		pwdata  <= {24'h0, wd};
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rv = prdata;
		ev = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// Idle edge so the next call never reassigns psel in this step
		@(posedge core_clk);
	endtask

	task automatic t_reset();
		for (int i = 0; i < 13; i++) begin
			bus(1'b0, IDX_PWM1_MIN_DUTY + 7'(i), 8'h00);
			chk(rv, {24'h0, rst_tab[i]});
		end
		chk({pwm1, pwm2, pwm3}, 24'h808080);
		bus(1'b0, 7'h7F, 8'h00);
		chk(ev, 1'b1);
	endtask

	task automatic t_fail_safe();
		bus(1'b1, IDX_PWM1_MIN_DUTY, 8'h40);
		bus(1'b1, IDX_IRQ_MASK, 8'h1F);
		tick(2);
		chk(pwm1, 8'h40);
		lc_t <= 10'd401;
		tick(3);
		chk({pwm1, pwm2, pwm3}, 24'hFFFFFF);
		chk(irq, 1'b1);
		lc_t <= 10'd384;
		tick(3);
		chk(pwm1, 8'hFF);
		lc_t <= 10'd383;
		tick(3);
		chk(pwm1, 8'h40);
		bus(1'b1, IDX_IRQ_STATUS, 8'h1F);
		tick(1);
		chk(irq, 1'b0);
		bus(1'b1, IDX_LOCAL_CRIT_LIMIT, 8'h80);
		lc_t <= 10'd1000;
		tick(3);
		chk(pwm3, 8'h80);
		lc_t <= 10'd200;
	endtask

	task automatic t_alarm();
		bus(1'b1, IDX_CTRL, 8'h08);
		r2_t <= 10'd401;
		tick(3);
		chk({pin_oe, pin}, 2'b10);
		r2_t <= 10'd200;
		tick(3);
		bus(1'b1, IDX_CTRL, 8'h00);
		bus(1'b1, IDX_IRQ_STATUS, 8'h1F);
		ext_pull <= 1'b1;
		tick(20);
		ext_pull <= 1'b0;
		bus(1'b0, IDX_IRQ_STATUS, 8'h00);
		chk(rv, 32'h10);
		chk(irq, 1'b1);
		bus(1'b1, IDX_IRQ_STATUS, 8'h1F);
	endtask

	task automatic t_fan_loop();
		bus(1'b1, IDX_CTRL, 8'h01);
		bus(1'b1, IDX_PWM2_MIN_DUTY, 8'h10);
		bus(1'b0, IDX_PWM2_MIN_DUTY, 8'h00);
		chk(rv, 32'h80);
		bus(1'b1, IDX_R1_LOCAL_HYSTERESIS, 8'h84);
		r1_t <= 10'd365;
		tick(3);
		chk({pwm1, pwm2}, 16'h4800);
		r1_t <= 10'd358;
		tick(3);
		chk(pwm1, 8'h40);
		r1_t <= 10'd330;
		tick(3);
		chk(pwm1, 8'h40);
		r1_t <= 10'd327;
		tick(3);
		chk(pwm1, 8'h00);
		bus(1'b1, IDX_REMOTE1_TEMP_OFFSET, 8'h04);
		r1_t <= 10'd365;
		tick(3);
		chk(pwm1, 8'h58);
		bus(1'b1, IDX_CTRL, 8'h05);
		tick(3);
		chk(pwm1, 8'h68);
	endtask

	task automatic t_lock();
		bus(1'b1, IDX_PIN_TREE_TEST_EN, 8'h01);
		tick(2);
		chk(test_on, 1'b1);
		bus(1'b1, IDX_PIN_TREE_TEST_EN, 8'h00);
		tick(2);
		chk(test_on, 1'b0);
		bus(1'b1, IDX_CTRL, 8'h03);
		bus(1'b1, IDX_REMOTE1_START_TEMP, 8'h10);
		bus(1'b0, IDX_REMOTE1_START_TEMP, 8'h00);
		chk(rv, 32'h5A);
		bus(1'b1, IDX_PIN_TREE_TEST_EN, 8'h01);
		tick(2);
		chk(test_on, 1'b0);
	endtask

	always @(posedge core_clk) begin
		cycles++;
		if (cycles > 20000) begin
			err_total++;
			stop_test();
		end
	end

	initial begin
		tick(2);
		resetn <= 1'b1;
		tick(1);
		t_reset();
		t_fail_safe();
		t_alarm();
		t_fan_loop();
		t_lock();
		stop_test();
	end
endmodule
